// File: rtl/aomd_datapath.v
`timescale 1ns/1ns
`include "aomd_consts.vh"
module aomd_datapath (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire [15:0] trap_vector_constant,
  output reg         bus_read,
  output reg         clock_stop,
  output wire        irq
);
  reg [10:0] ctrl_reg;
  reg [15:0] operand_hold_register;
  reg [15:0] opb_reg;
  reg [15:0] res_reg;
  reg [15:0] aux_shift_register;
  reg [15:0] lowest_word_shift_reg;
  reg [15:0] second_word_shift_reg;
  reg        option_carry_bit;
  reg        option_overflow_bit;
  reg        option_zero_bit;
  reg        res_carry_reg;
  reg [15:0] cnt_reg;
  reg [15:0] addr_reg;
  reg [3:0]  src_reg;
  reg [3:0]  dst_reg;
  reg [3:0]  ph_reg;
  reg [1:0]  ist_reg;
  reg [1:0]  imsk_reg;
  reg        argument_select_flop;
  reg        b_constant_select;
  reg [15:0] rsel_reg;
  reg [31:0] rd_word;
  wire [4:0] op = ctrl_reg[`AOMD_CTRL_OP_HI:0];
  wire       wr = psel & penable & pwrite;
  wire       rd_any = psel & ~pwrite;
  wire       go = wr && paddr == `AOMD_CTRL_OFF && pwdata[`AOMD_CTRL_GO];
  wire [15:0] alu_add = operand_hold_register + opb_reg;
  wire [15:0] alu_sub = operand_hold_register - opb_reg;
  reg        done_ev;
  reg        v_ev;

  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign irq = |(ist_reg & imsk_reg);

  function mapped;
    input [11:0] a;
    begin
      mapped = (a <= `AOMD_DST_OFF) && (a[1:0] == 2'b00);
    end
  endfunction

  function [15:0] pair_odd;
    input [3:0] r;
    begin
      pair_odd = {12'h000, r | 4'h1};
    end
  endfunction

  // value minus constant select minus one, a decrement by two when select is set
  function [15:0] minus_two;
    input [15:0] v;
    input        c;
    begin
      minus_two = v - {15'h0000, c} - 16'h0001;
    end
  endfunction

  // register read word
  always @* begin
    rd_word = 32'h00000000;
    if (rd_any && mapped(paddr)) begin
      case (paddr)
        `AOMD_CTRL_OFF: rd_word = {21'h0, ctrl_reg};
        `AOMD_OPA_OFF:  rd_word = {16'h0000, operand_hold_register};
        `AOMD_OPB_OFF:  rd_word = {16'h0000, opb_reg};
        `AOMD_RES_OFF:  rd_word = {16'h0000, res_reg};
        `AOMD_AUX_OFF:  rd_word = {16'h0000, aux_shift_register};
        `AOMD_LOW_OFF:  rd_word = {16'h0000, lowest_word_shift_reg};
        `AOMD_SEC_OFF:  rd_word = {16'h0000, second_word_shift_reg};
        `AOMD_FLAG_OFF: rd_word = {27'h0, ph_reg == `AOMD_PH_IDLE, res_carry_reg,
                                   option_zero_bit, option_overflow_bit, option_carry_bit};
        `AOMD_CNT_OFF:  rd_word = {16'h0000, cnt_reg};
        `AOMD_ADDR_OFF: rd_word = {16'h0000, addr_reg};
        `AOMD_IST_OFF:  rd_word = {30'h0, ist_reg};
        `AOMD_IMSK_OFF: rd_word = {30'h0, imsk_reg};
        `AOMD_SRC_OFF:  rd_word = {12'h000, rsel_reg[3:0], 12'h000, src_reg};
        `AOMD_DST_OFF:  rd_word = {28'h0000000, dst_reg};
        default:        rd_word = 32'h00000000;
      endcase
    end
  end

  // read data captured in the setup phase, steady through the access phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable) begin
      prdata <= rd_word;
    end
  end

  // micro-word sequencer: p1, p2, p3 then idle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph_reg <= `AOMD_PH_IDLE;
    end else begin
      case (ph_reg)
        `AOMD_PH_IDLE: begin
          ph_reg <= go ? `AOMD_PH_P1 : `AOMD_PH_IDLE;
        end
        `AOMD_PH_P1: begin
          ph_reg <= `AOMD_PH_P2;
        end
        `AOMD_PH_P2: begin
          ph_reg <= `AOMD_PH_P3;
        end
        `AOMD_PH_P3: begin
          ph_reg <= `AOMD_PH_IDLE;
        end
        default: begin
          ph_reg <= `AOMD_PH_IDLE;
        end
      endcase
    end
  end

  always @* begin
    done_ev = (ph_reg == `AOMD_PH_P3);
    v_ev = (ph_reg == `AOMD_PH_P2) && (op == `AOMD_OP_SHL) &&
           (operand_hold_register[15] != operand_hold_register[14]);
  end

  // datapath: all nonblocking, so sources sample before update
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= 11'h000;
      operand_hold_register <= 16'h0000;
      opb_reg <= 16'h0000;
      res_reg <= 16'h0000;
      aux_shift_register <= 16'h0000;
      lowest_word_shift_reg <= 16'h0000;
      second_word_shift_reg <= 16'h0000;
      option_carry_bit <= 1'b0;
      option_overflow_bit <= 1'b0;
      option_zero_bit <= 1'b0;
      res_carry_reg <= 1'b0;
      cnt_reg <= 16'h0000;
      addr_reg <= 16'h0000;
      src_reg <= 4'h0;
      dst_reg <= 4'h0;
      imsk_reg <= 2'b00;
      argument_select_flop <= 1'b0;
      b_constant_select <= 1'b0;
      rsel_reg <= 16'h0000;
      bus_read <= 1'b0;
      clock_stop <= 1'b0;
    end else begin
      bus_read <= 1'b0;
      if (ph_reg == `AOMD_PH_IDLE && wr) begin
        case (paddr)
          `AOMD_CTRL_OFF: begin
            ctrl_reg <= pwdata[10:0];
            argument_select_flop <= pwdata[`AOMD_CTRL_ARG];
            b_constant_select <= pwdata[`AOMD_CTRL_BCS];
            clock_stop <= 1'b0;
          end
          `AOMD_OPA_OFF: begin
            operand_hold_register <= pwdata[15:0];
          end
          `AOMD_OPB_OFF: begin
            opb_reg <= pwdata[15:0];
          end
          `AOMD_RES_OFF: begin
            res_reg <= pwdata[15:0];
          end
          `AOMD_AUX_OFF: begin
            aux_shift_register <= pwdata[15:0];
          end
          `AOMD_LOW_OFF: begin
            lowest_word_shift_reg <= pwdata[15:0];
          end
          `AOMD_SEC_OFF: begin
            second_word_shift_reg <= pwdata[15:0];
          end
          `AOMD_FLAG_OFF: begin
            option_carry_bit <= pwdata[`AOMD_FC];
            option_overflow_bit <= pwdata[`AOMD_FV];
            option_zero_bit <= pwdata[`AOMD_FZ];
            res_carry_reg <= pwdata[`AOMD_FR];
          end
          `AOMD_CNT_OFF: begin
            cnt_reg <= pwdata[15:0];
          end
          `AOMD_ADDR_OFF: begin
            addr_reg <= pwdata[15:0];
          end
          `AOMD_SRC_OFF: begin
            src_reg <= pwdata[3:0];
          end
          `AOMD_DST_OFF: begin
            dst_reg <= pwdata[3:0];
          end
          default: ;
        endcase
      end
      if (wr && paddr == `AOMD_IMSK_OFF) begin
        imsk_reg <= pwdata[1:0];
      end
      if (ph_reg == `AOMD_PH_P1) begin
        case (op)
          `AOMD_OP_CNTUP: begin
            cnt_reg <= cnt_reg + 16'h0001;
          end
          `AOMD_OP_CNTDN: begin
            cnt_reg <= cnt_reg - 16'h0001;
          end
          `AOMD_OP_CHR: begin
            lowest_word_shift_reg <= {second_word_shift_reg[0], lowest_word_shift_reg[15:1]};
            second_word_shift_reg <= {aux_shift_register[0], second_word_shift_reg[15:1]};
            aux_shift_register <= {operand_hold_register[0], aux_shift_register[15:1]};
            operand_hold_register <= {res_carry_reg, res_reg[15:1]};
          end
          `AOMD_OP_CHL: begin
            lowest_word_shift_reg <= {lowest_word_shift_reg[14:0], 1'b0};
            second_word_shift_reg <= {second_word_shift_reg[14:0], lowest_word_shift_reg[15]};
            aux_shift_register <= {aux_shift_register[14:0], second_word_shift_reg[15]};
            operand_hold_register <= {operand_hold_register[14:0], aux_shift_register[15]};
          end
          `AOMD_OP_ODDRD: begin
            rsel_reg <= pair_odd(src_reg);
          end
          default: ;
        endcase
      end
      if (ph_reg == `AOMD_PH_P2) begin
        case (op)
          `AOMD_OP_CONDADD: begin
            case ({aux_shift_register[0], option_carry_bit})
              2'b00:   res_reg <= operand_hold_register;
              2'b11:   res_reg <= operand_hold_register;
              2'b10:   res_reg <= alu_add;
              default: res_reg <= alu_sub;
            endcase
          end
          `AOMD_OP_DEC2: begin
            res_reg <= minus_two(opb_reg, b_constant_select);
            addr_reg <= minus_two(opb_reg, b_constant_select);
            bus_read <= 1'b1;
          end
          `AOMD_OP_TRAPV: begin
            res_reg <= trap_vector_constant;
          end
          `AOMD_OP_LOADSF: begin
            res_reg <= opb_reg;
            res_carry_reg <= alu_add[15];
            option_carry_bit <= alu_add[0];
          end
          `AOMD_OP_SHR: begin
            res_reg <= {res_carry_reg, res_reg[15:1]};
          end
          `AOMD_OP_ODDRD: begin
            operand_hold_register <= rsel_reg;
          end
          `AOMD_OP_SHL: begin
            res_reg <= opb_reg + opb_reg;
            if (operand_hold_register[15] != operand_hold_register[14]) begin
              option_overflow_bit <= 1'b1;
            end
          end
          `AOMD_OP_AUXL: begin
            aux_shift_register <= {aux_shift_register[14:0], 1'b0};
          end
          `AOMD_OP_AUXR: begin
            aux_shift_register <= {1'b0, aux_shift_register[15:1]};
          end
          `AOMD_OP_ORZ: begin
            res_reg <= opb_reg | operand_hold_register;
            option_zero_bit <= ((opb_reg | operand_hold_register) == `AOMD_ZERO16);
          end
          `AOMD_OP_NEG1: begin
            res_reg <= ~operand_hold_register;
          end
          `AOMD_OP_NEG2: begin
            res_reg <= `AOMD_ZERO16 - opb_reg;
          end
          `AOMD_OP_FDST: begin
            dst_reg <= argument_select_flop ? `AOMD_FP_EVEN : `AOMD_FP_ODD;
          end
          `AOMD_OP_SIGNX: begin
            res_reg <= opb_reg ^ lowest_word_shift_reg;
          end
          `AOMD_OP_UNEXP: begin
            res_reg <= {8'h00, opb_reg[15:8]};
          end
          `AOMD_OP_UNFRAC: begin
            res_reg <= `AOMD_HIDDEN + {8'h00, opb_reg[7:0]};
          end
          default: ;
        endcase
      end
      if (ph_reg == `AOMD_PH_P3 && op == `AOMD_OP_DEC2) begin
        clock_stop <= 1'b1;
      end
    end
  end

  // sticky interrupt status: bit0 done, bit1 overflow; set wins over clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ist_reg <= 2'b00;
    end else begin
      ist_reg <= (ist_reg & ~((wr && paddr == `AOMD_IST_OFF) ? pwdata[1:0] : 2'b00)) |
                 {v_ev, done_ev};
    end
  end
endmodule // aomd_datapath

// File: rtl/aomd_consts.vh
`ifndef AOMD_CONSTS_VH
`define AOMD_CONSTS_VH
// apb register byte offsets
`define AOMD_CTRL_OFF   12'h000
`define AOMD_OPA_OFF    12'h004
`define AOMD_OPB_OFF    12'h008
`define AOMD_RES_OFF    12'h00c
`define AOMD_AUX_OFF    12'h010
`define AOMD_LOW_OFF    12'h014
`define AOMD_SEC_OFF    12'h018
`define AOMD_FLAG_OFF   12'h01c
`define AOMD_CNT_OFF    12'h020
`define AOMD_ADDR_OFF   12'h024
`define AOMD_IST_OFF    12'h028
`define AOMD_IMSK_OFF   12'h02c
`define AOMD_SRC_OFF    12'h030
`define AOMD_DST_OFF    12'h034
// micro-operation codes, ctrl[4:0]
`define AOMD_OP_CONDADD 5'h01
`define AOMD_OP_DEC2    5'h02
`define AOMD_OP_TRAPV   5'h03
`define AOMD_OP_CNTUP   5'h04
`define AOMD_OP_CNTDN   5'h05
`define AOMD_OP_LOADSF  5'h06
`define AOMD_OP_SHR     5'h07
`define AOMD_OP_ODDRD   5'h08
`define AOMD_OP_SHL     5'h09
`define AOMD_OP_AUXL    5'h0a
`define AOMD_OP_AUXR    5'h0b
`define AOMD_OP_ORZ     5'h0c
`define AOMD_OP_NEG1    5'h0d
`define AOMD_OP_NEG2    5'h0e
`define AOMD_OP_FDST    5'h0f
`define AOMD_OP_SIGNX   5'h10
`define AOMD_OP_UNEXP   5'h11
`define AOMD_OP_UNFRAC  5'h12
`define AOMD_OP_CHR     5'h13
`define AOMD_OP_CHL     5'h14
// ctrl fields
`define AOMD_CTRL_OP_HI 4
`define AOMD_CTRL_GO    8
`define AOMD_CTRL_ARG   9
`define AOMD_CTRL_BCS   10
// flag bits
`define AOMD_FC 0
`define AOMD_FV 1
`define AOMD_FZ 2
`define AOMD_FR 3
// constants
`define AOMD_HIDDEN     16'h0100
`define AOMD_FP_EVEN    4'hc
`define AOMD_FP_ODD     4'hd
`define AOMD_ZERO16     16'h0000
// pulse phases, one-hot
`define AOMD_PH_IDLE    4'h1
`define AOMD_PH_P1      4'h2
`define AOMD_PH_P2      4'h4
`define AOMD_PH_P3      4'h8
`endif

// File: tb/aomd_asserts.sv
`timescale 1ns/1ns
`include "aomd_consts.vh"
module aomd_asserts (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        bus_read,
  input wire        clock_stop
);
  wire cw  = psel & penable & pwrite & (paddr == `AOMD_CTRL_OFF);
  wire go2 = cw & pwdata[`AOMD_CTRL_GO] & (pwdata[4:0] == `AOMD_OP_DEC2);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_GO_READ: assert property (go2 |-> ##3 bus_read) else $error("no read start");
  AST_READ_PULSE: assert property (bus_read |=> !bus_read) else $error("read start too long");
  AST_READ_CAUSE: assert property (bus_read |-> $past(go2, 3)) else $error("stray read start");
  AST_STOP_AFTER: assert property (bus_read |=> clock_stop) else $error("clock not stopped");
  AST_STOP_CAUSE: assert property ($rose(clock_stop) |-> $past(bus_read)) else $error("stray stop");
  AST_STOP_CLR: assert property (cw && clock_stop |=> !clock_stop) else $error("stop kept");
  AST_STOP_HOLD: assert property (clock_stop && !cw |=> clock_stop) else $error("stop lost");
  AST_UNMAPPED: assert property (psel && penable && !pwrite && paddr == 12'h040 |-> prdata == 32'h0)
    else $error("unmapped read not zero");
endmodule // aomd_asserts

// File: tb/aomd_host_model.sv
`timescale 1ns/1ns
module aomd_host_model (
  input  wire [1:0]  err_sel,
  output wire [15:0] trap_vector_constant
);
  // one vector per pending error kind, values arbitrary
  assign trap_vector_constant = {11'h000, err_sel, 3'h4};
endmodule // aomd_host_model

// File: tb/aomd_datapath_tb_top.sv
`timescale 1ns/1ns
`include "aomd_consts.vh"
module aomd_datapath_tb_top;
  reg         pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  reg  [11:0] paddr = 12'h000;
  reg  [31:0] pwdata = 32'h0, q, z;
  reg  [15:0] a, b;
  reg  [1:0]  s, err_sel = 2'h0;
  wire [31:0] prdata;
  wire [15:0] tvc;
  wire        pready, pslverr, bus_read, clock_stop, irq;
  integer     num_errors = 0, n_tests = 0, i, k;
  aomd_host_model u_aomd_host_model (.err_sel(err_sel), .trap_vector_constant(tvc));
  aomd_datapath u_aomd_datapath (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .trap_vector_constant(tvc), .bus_read(bus_read), .clock_stop(clock_stop), .irq(irq));
  initial forever #2 pclk = ~pclk;
  initial begin
    #100000;
    num_errors = num_errors + 1;
    end_sim;
  end
  task end_sim;
    if (num_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input [31:0] g, input [31:0] e);
    n_tests = n_tests + 1;
    if (g !== e) begin
      num_errors = num_errors + 1;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // one apb transfer, held until pready is seen high
  task apb(input [11:0] ad, input w, input [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= ad;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // start a micro-word and poll until idle
  task run(input [31:0] c);
    apb(`AOMD_CTRL_OFF, 1'b1, c | 32'h100);
    q = 32'h0;
    while (q[4] !== 1'b1) apb(`AOMD_FLAG_OFF, 1'b0, 32'h0);
  endtask
  // register to read back and its expected value
  function [27:0] ex(input [4:0] o, input [15:0] p, input [15:0] r, input [1:0] m);
    case (o)
      `AOMD_OP_CONDADD: ex = {`AOMD_RES_OFF, (m == 2'b10) ? p + r : (m == 2'b01) ? p - r : p};
      `AOMD_OP_DEC2: ex = {`AOMD_RES_OFF, r - {15'h0, m[0]} - 16'h1};
      `AOMD_OP_TRAPV: ex = {`AOMD_RES_OFF, 16'h0004 + {11'h0, m, 3'h0}};
      `AOMD_OP_CNTUP: ex = {`AOMD_CNT_OFF, 8'h00, p[7:0] | 8'h01} + 28'h1;
      `AOMD_OP_CNTDN: ex = {`AOMD_CNT_OFF, 8'h00, p[7:0] | 8'h01} - 28'h1;
      `AOMD_OP_AUXL: ex = {`AOMD_AUX_OFF, p[14:1], m[1], 1'b0};
      `AOMD_OP_AUXR: ex = {`AOMD_AUX_OFF, 1'b0, p[15:1]};
      `AOMD_OP_NEG1: ex = {`AOMD_RES_OFF, ~p};
      `AOMD_OP_NEG2: ex = {`AOMD_RES_OFF, 16'h0000 - r};
      `AOMD_OP_UNEXP: ex = {`AOMD_RES_OFF, 8'h00, r[15:8]};
      `AOMD_OP_UNFRAC: ex = {`AOMD_RES_OFF, 16'h0100 + {8'h00, r[7:0]}};
      `AOMD_OP_LOADSF: ex = {`AOMD_RES_OFF, r};
      `AOMD_OP_SHR: ex = {`AOMD_RES_OFF, 1'b0, r[15:1]};
      `AOMD_OP_SHL: ex = {`AOMD_RES_OFF, r + r};
      `AOMD_OP_FDST: ex = {`AOMD_DST_OFF, 12'h000, m[1] ? 4'hc : 4'hd};
      `AOMD_OP_SIGNX: ex = {`AOMD_RES_OFF, r ^ p};
      `AOMD_OP_CHR: ex = {`AOMD_OPA_OFF, 1'b0, r[15:1]};
      `AOMD_OP_CHL: ex = {`AOMD_LOW_OFF, p[14:0], 1'b0};
      default: ex = {12'hfff, 16'h0};
    endcase
  endfunction
  initial begin
    z = $urandom(32'h9002ffb4);
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(12'h040, 1'b1, 32'hffffffff);
    for (i = 0; i <= 32'h40; i = i + 4) begin
      apb(i[11:0], 1'b0, 32'h0);
      chk(q, (i == `AOMD_FLAG_OFF) ? 32'h10 : 32'h0);
    end
    for (k = 1; k <= 20; k = k + 1) begin
      for (i = 0; i < 4; i = i + 1) begin
        {a, b} = $urandom;
        z = $urandom;
        s = z[1:0] ^ i[1:0];
        if (i == 0) b = 16'h0000;
        apb(`AOMD_OPA_OFF, 1'b1, {16'h0, a});
        apb(`AOMD_OPB_OFF, 1'b1, {16'h0, b});
        apb(`AOMD_AUX_OFF, 1'b1, {16'h0, a[15:1], s[1]});
        apb(`AOMD_FLAG_OFF, 1'b1, {31'h0, s[0]});
        apb(`AOMD_CNT_OFF, 1'b1, {24'h0, a[7:0] | 8'h01});
        apb(`AOMD_RES_OFF, 1'b1, {16'h0, b});
        apb(`AOMD_LOW_OFF, 1'b1, {16'h0, a});
        err_sel <= s;
        run({21'h0, s[0] & (k == `AOMD_OP_DEC2), s[1] & (k == `AOMD_OP_FDST), 4'h0, k[4:0]});
        z = {4'h0, ex(k[4:0], a, b, s)};
        if (z[27:16] != 12'hfff) begin
          apb(z[27:16], 1'b0, 32'h0);
          chk(q, {16'h0, z[15:0]});
        end
        if (k == `AOMD_OP_DEC2) begin
          apb(`AOMD_ADDR_OFF, 1'b0, 32'h0);
          chk(q, {16'h0, z[15:0]});
          chk({31'h0, clock_stop}, 32'h1);
        end
      end
    end
    apb(`AOMD_OPA_OFF, 1'b1, 32'h0);
    apb(`AOMD_OPB_OFF, 1'b1, 32'h0);
    run({27'h0, `AOMD_OP_ORZ});
    chk({31'h0, q[`AOMD_FZ]}, 32'h1);
    apb(`AOMD_OPB_OFF, 1'b1, 32'h8000);
    run({27'h0, `AOMD_OP_ORZ});
    chk({31'h0, q[`AOMD_FZ]}, 32'h0);
    apb(`AOMD_SRC_OFF, 1'b1, 32'h4);
    run({27'h0, `AOMD_OP_ODDRD});
    apb(`AOMD_SRC_OFF, 1'b0, 32'h0);
    chk({28'h0, q[19:16]}, 32'h5);
    apb(`AOMD_IST_OFF, 1'b0, 32'h0);
    chk({31'h0, q[0]}, 32'h1);
    chk({31'h0, irq}, 32'h0);
    apb(`AOMD_IMSK_OFF, 1'b1, 32'h1);
    #1;
    chk({31'h0, irq}, 32'h1);
    apb(`AOMD_IST_OFF, 1'b1, 32'h3);
    #1;
    chk({31'h0, irq}, 32'h0);
    end_sim;
  end
endmodule // aomd_datapath_tb_top
bind aomd_datapath aomd_asserts u_aomd_asserts (.*);
